// [istu_top.sv]
`timescale 1ns/1ns
// Function
// - Start sets bus busy; address follows
// - Own address match selects receive or transmit
// - Receive ninth clock drives acknowledge bit
// - Ninth rise sets interface interrupt flag
// - Second address match also sets transfer flag
// - Ninth rise moves byte, sets receive full
// - Data read clears full; reload sets again
// - Stop clears busy; after an own match sets end flag, or error end flag if misaligned
// - Read address match acknowledges, sets transmit empty
// - Empty transmit buffer holds clock low
// - Data write loads shifter, flags set again
// - Transmit ninth rise stores master acknowledge
// - Dummy read after transmit releases data line
// - Full or empty buffer holds clock low
// - Two latches filter clock and data inputs
// - Forced reset clears buffer flags, sequencer, outputs
// - Forced reset keeps registers and counter
// - Forced reset releases both lines at once
// - Each channel raises own gated interrupt
module istu_top
   import istu_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              scl_in,
   input  wire logic              sda_in,
   output logic                   scl_o,
   output logic                   scl_oe,
   output logic                   sda_o,
   output logic                   sda_oe,
   input  wire logic [ADDR_W-1:0] own_addr,
   input  wire logic [ADDR_W-1:0] second_addr,
   input  wire logic              interface_enable,
   input  wire logic              handshake_hold_enable,
   input  wire logic              ack_check_enable,
   input  wire logic              end_irq_mask,
   input  wire logic              iface_irq_enable,
   input  wire logic              channel_id,
   input  wire logic              ack_bit_wr,
   input  wire logic              ack_bit_wdata,
   input  wire logic              tsel_clr,
   input  wire logic              iface_irq_clr,
   input  wire logic              status_clr,
   input  wire logic              clear_select_wr,
   input  wire logic [3:0]        clear_select_bits,
   input  wire logic              data_wr,
   input  wire logic [BYTE_W-1:0] data_wr_byte,
   input  wire logic              data_rd,
   output logic [BYTE_W-1:0]      data_rd_byte,
   output logic                   acknowledge_bit,
   output logic                   transmit_select,
   output logic                   bus_busy_flag,
   output logic                   receive_full_flag,
   output logic                   transmit_empty_flag,
   output logic                   end_flag,
   output logic                   error_end_condition_flag,
   output logic                   second_address_match_flag,
   output logic                   transfer_irq_flag,
   output logic                   iface_irq_flag,
   output logic                   channel0_interrupt,
   output logic                   channel1_interrupt
);
   logic [1:0]        sync1_reg, sync2_reg, nca_reg, ncb_reg, filt_reg, prev_reg;
   istu_state_e       state_reg;
   logic [2:0]        frame_bit_counter_reg;
   logic              after8_reg, ack_ph_reg, after9_reg;
   logic [BYTE_W-1:0] shift_register_reg, tx_buf_reg, rx_buf_reg;
   logic              match_reg, rw_reg, addressed_reg, need_load_reg, tx_loaded_reg;
   logic              scl_hold_reg, sda_oe_reg, ace_prev_reg;
   logic              ack_reg, tsel_reg, busy_reg, rx_full_reg, tx_empty_reg;
   logic              end_reg, err_end_reg, sec_reg, xfer_reg, irq_reg;
   logic              ch0_reg, ch1_reg, line_zero_reg;
   logic              fifo_in_ready, fifo_out_valid;
   logic [BYTE_W-1:0] fifo_out_data;

   // Line events, all from the filtered levels
   wire scl_f      = filt_reg[0];
   wire sda_f      = filt_reg[1];
   wire scl_rise   = scl_f & ~prev_reg[0];
   wire scl_fall   = ~scl_f & prev_reg[0];
   wire start_det  = scl_f & prev_reg[0] & ~sda_f & prev_reg[1];
   wire stop_det   = scl_f & prev_reg[0] & sda_f & ~prev_reg[1];
   wire st_addr    = (state_reg == ST_ADDR);
   wire st_rx      = (state_reg == ST_RX);
   wire st_tx      = (state_reg == ST_TX);
   wire force_rst  = ~interface_enable | (clear_select_wr & (clear_select_bits == CLR_ALL));
   wire data_rise  = scl_rise & ~after8_reg & ~ack_ph_reg;
   wire eighth_rise = data_rise & (frame_bit_counter_reg == LAST_BIT);
   wire ack_start  = scl_fall & after8_reg;
   wire ninth_rise = scl_rise & ack_ph_reg;
   wire ninth_fall = scl_fall & after9_reg;
   wire match_own  = (shift_register_reg[ADDR_W-1:0] == own_addr);
   wire match_sec  = (shift_register_reg[ADDR_W-1:0] == second_addr);
   wire addr_done  = ninth_rise & st_addr & match_reg;
   wire rx_done    = ninth_rise & st_rx;
   wire tx_done    = ninth_rise & st_tx;
   wire tx_load    = st_tx & ~force_rst & ((tx_done & ~tx_empty_reg)
                                           | (need_load_reg & ~tx_empty_reg));
   wire tx_shift   = scl_fall & st_tx & tx_loaded_reg & ~after8_reg & ~ack_ph_reg & ~after9_reg;
   wire rx_load    = fifo_out_valid & ~rx_full_reg & ~force_rst;
   wire tx_release = data_rd & st_tx & ~tsel_reg;
   wire stop_flag  = stop_det & addressed_reg;
   // The clock rise that precedes a stop has already counted as a first bit
   wire aligned    = (frame_bit_counter_reg == (FIRST_BIT + BIT_STEP))
                   & ~after8_reg & ~ack_ph_reg;
   wire hold_cond  = (st_tx & need_load_reg)
                   | (st_rx & (~fifo_in_ready | (handshake_hold_enable & rx_full_reg)));
   wire sda_ack    = ack_ph_reg & ((st_addr & match_reg & (rw_reg | ~ack_reg))
                                   | (st_rx & ~ack_reg));
   wire sda_tx     = st_tx & tx_loaded_reg & ~after8_reg & ~ack_ph_reg & ~after9_reg
                   & ~shift_register_reg[BYTE_W-1];
   wire irq_set    = addr_done | rx_done | tx_done | tx_load | rx_load
                   | (stop_flag & ~end_irq_mask);
   wire xfer_set   = (addr_done | rx_done) & sec_reg;

   // Two flops bring the pins in, then two latches and a match detector
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_reg <= LINES_IDLE;
         sync2_reg <= LINES_IDLE;
         nca_reg   <= LINES_IDLE;
         ncb_reg   <= LINES_IDLE;
         filt_reg  <= LINES_IDLE;
         prev_reg  <= LINES_IDLE;
      end else begin
         sync1_reg <= {sda_in, scl_in};
         sync2_reg <= sync1_reg;
         nca_reg   <= sync2_reg;
         ncb_reg   <= nca_reg;
         filt_reg  <= (nca_reg == ncb_reg) ? nca_reg : filt_reg;
         prev_reg  <= filt_reg;
      end
   end

   // Frame bit counter survives a forced reset; only a start or sys_rst clears it
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         frame_bit_counter_reg <= FIRST_BIT;
      end else if (start_det) begin
         frame_bit_counter_reg <= FIRST_BIT;
      end else if (data_rise) begin
         frame_bit_counter_reg <= frame_bit_counter_reg + BIT_STEP;
      end
   end

   // Transfer sequencer
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg     <= ST_IDLE;
         after8_reg    <= 1'b0;
         ack_ph_reg    <= 1'b0;
         after9_reg    <= 1'b0;
         match_reg     <= 1'b0;
         rw_reg        <= 1'b0;
         addressed_reg <= 1'b0;
      end else if (force_rst) begin
         state_reg     <= ST_IDLE;
         after8_reg    <= 1'b0;
         ack_ph_reg    <= 1'b0;
         after9_reg    <= 1'b0;
         addressed_reg <= 1'b0;
      end else if (start_det) begin
         state_reg     <= ST_ADDR;
         after8_reg    <= 1'b0;
         ack_ph_reg    <= 1'b0;
         after9_reg    <= 1'b0;
         addressed_reg <= 1'b0;
      end else if (stop_det) begin
         state_reg     <= ST_IDLE;
         addressed_reg <= 1'b0;
      end else begin
         after8_reg <= eighth_rise | (after8_reg & ~ack_start);
         ack_ph_reg <= ack_start | (ack_ph_reg & ~ninth_rise);
         after9_reg <= ninth_rise | (after9_reg & ~ninth_fall);
         if (eighth_rise && st_addr) begin
            match_reg <= match_own | match_sec;
            rw_reg    <= sda_f;
            if (!(match_own | match_sec)) begin
               state_reg <= ST_SKIP;
            end
         end
         if (addr_done) begin
            state_reg     <= rw_reg ? ST_TX : ST_RX;
            addressed_reg <= 1'b1;
         end
         if (tx_release) begin
            state_reg <= ST_SKIP;
         end
      end
   end

   // Shift register: receive shifts on the rise, transmit on the fall
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         shift_register_reg <= BYTE_ZERO;
      end else if (tx_load) begin
         shift_register_reg <= tx_buf_reg;
      end else if (data_rise && (st_addr || st_rx)) begin
         shift_register_reg <= {shift_register_reg[BYTE_W-2:0], sda_f};
      end else if (tx_shift) begin
         shift_register_reg <= {shift_register_reg[BYTE_W-2:0], 1'b0};
      end
   end

   // Transmit buffer, empty flag and load tracking
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_buf_reg    <= BYTE_ZERO;
         tx_empty_reg  <= 1'b0;
         need_load_reg <= 1'b0;
         tx_loaded_reg <= 1'b0;
      end else if (force_rst) begin
         tx_empty_reg  <= 1'b0;
         need_load_reg <= 1'b0;
         tx_loaded_reg <= 1'b0;
      end else begin
         if (data_wr) begin
            tx_buf_reg <= data_wr_byte;
         end
         if (addr_done && rw_reg) begin
            tx_empty_reg  <= 1'b1;
            need_load_reg <= 1'b1;
         end else if (tx_load) begin
            tx_empty_reg  <= 1'b1;
            need_load_reg <= 1'b0;
            tx_loaded_reg <= 1'b1;
         end else if (data_wr) begin
            tx_empty_reg <= 1'b0;
         end else if (tx_done) begin
            need_load_reg <= 1'b1;
         end
         if (ack_start && st_tx) begin
            tx_loaded_reg <= 1'b0;
         end
      end
   end

   // Receive buffer fed from the queue; a read frees it for the next byte
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_buf_reg  <= BYTE_ZERO;
         rx_full_reg <= 1'b0;
      end else if (force_rst) begin
         rx_full_reg <= 1'b0;
      end else if (rx_load) begin
         rx_buf_reg  <= fifo_out_data;
         rx_full_reg <= 1'b1;
      end else if (data_rd && !st_tx) begin
         rx_full_reg <= 1'b0;
      end
   end

   // Queue absorbs bursts; when it fills, the clock is held after the frame
   istu_fifo #(
      .W (BYTE_W),
      .D (FIFO_DEPTH)
   ) u_rx_fifo (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .in_valid  (rx_done),
      .in_data   (shift_register_reg),
      .in_ready  (fifo_in_ready),
      .out_valid (fifo_out_valid),
      .out_data  (fifo_out_data),
      .out_ready (rx_load)
   );

   // Pin drive latches; the outputs themselves only ever pull low
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         scl_hold_reg  <= 1'b0;
         sda_oe_reg    <= 1'b0;
         line_zero_reg <= 1'b0;
      end else if (force_rst) begin
         scl_hold_reg <= 1'b0;
         sda_oe_reg   <= 1'b0;
      end else begin
         scl_hold_reg <= hold_cond & (scl_hold_reg | ninth_fall);
         sda_oe_reg   <= sda_ack | sda_tx;
      end
   end

   // Status and control bits; a hardware set beats a software clear
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_reg      <= 1'b0;
         ace_prev_reg <= 1'b0;
         tsel_reg     <= 1'b0;
         busy_reg     <= 1'b0;
         end_reg      <= 1'b0;
         err_end_reg  <= 1'b0;
         sec_reg      <= 1'b0;
         xfer_reg     <= 1'b0;
         irq_reg      <= 1'b0;
      end else begin
         ace_prev_reg <= ack_check_enable;
         if (tx_done) begin
            ack_reg <= sda_f;
         end else if (ace_prev_reg && !ack_check_enable) begin
            ack_reg <= 1'b0;
         end else if (ack_bit_wr) begin
            ack_reg <= ack_bit_wdata;
         end
         tsel_reg <= (addr_done & rw_reg) | (tsel_reg & ~tsel_clr);
         busy_reg <= start_det | (busy_reg & ~stop_det);
         end_reg  <= (stop_flag & aligned) | (end_reg & ~status_clr);
         err_end_reg <= (stop_flag & ~aligned) | (err_end_reg & ~status_clr);
         if (eighth_rise && st_addr && (match_own | match_sec)) begin
            sec_reg <= match_sec & ~match_own;
         end
         xfer_reg <= xfer_set | (xfer_reg & ~status_clr);
         irq_reg  <= irq_set | (irq_reg & ~iface_irq_clr);
      end
   end

   // Interrupt requests follow flag and enable; channel_id picks channel 0 or 1
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ch0_reg <= 1'b0;
         ch1_reg <= 1'b0;
      end else begin
         ch0_reg <= irq_reg & iface_irq_enable & ~channel_id;
         ch1_reg <= irq_reg & iface_irq_enable & channel_id;
      end
   end

   assign scl_o                     = line_zero_reg;
   assign sda_o                     = line_zero_reg;
   assign scl_oe                    = scl_hold_reg;
   assign sda_oe                    = sda_oe_reg;
   assign data_rd_byte              = rx_buf_reg;
   assign acknowledge_bit           = ack_reg;
   assign transmit_select           = tsel_reg;
   assign bus_busy_flag             = busy_reg;
   assign receive_full_flag         = rx_full_reg;
   assign transmit_empty_flag       = tx_empty_reg;
   assign end_flag                  = end_reg;
   assign error_end_condition_flag  = err_end_reg;
   assign second_address_match_flag = sec_reg;
   assign transfer_irq_flag         = xfer_reg;
   assign iface_irq_flag            = irq_reg;
   assign channel0_interrupt        = ch0_reg;
   assign channel1_interrupt        = ch1_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_write_clears;
      data_wr && need_load_reg && st_tx && tx_empty_reg && !force_rst && !tx_load;
   endsequence
   sequence s_reload;
      !tx_empty_reg ##1 (tx_empty_reg && irq_reg);
   endsequence

   a_start_busy: assert property (start_det |=> bus_busy_flag)
      else $error("Start did not set bus busy");
   a_stop_busy: assert property (stop_det && !start_det |=> !bus_busy_flag)
      else $error("Stop did not clear bus busy");
   a_addr_skip: assert property (eighth_rise && st_addr && !force_rst && !start_det
                                 && !stop_det && !(match_own | match_sec)
                                 |=> state_reg == ST_SKIP)
      else $error("Mismatched address not ignored");
   a_rx_ack_drive: assert property (ack_ph_reg && st_rx && !ack_reg && !force_rst
                                    |=> sda_oe)
      else $error("Receive acknowledge not driven");
   a_rx_irq_set: assert property (rx_done && !force_rst && !start_det && !stop_det
                                  |=> iface_irq_flag)
      else $error("Ninth rise did not set interrupt flag");
   a_tx_hold: assert property (ninth_fall && hold_cond && !force_rst |=> scl_oe)
      else $error("Clock not held while transmit empty");
   a_tx_write_load: assert property (s_write_clears |=> s_reload)
      else $error("Write did not reload the shifter");
   a_noise_filter: assert property (filt_reg != $past(filt_reg)
                                    |-> $past(nca_reg == ncb_reg))
      else $error("Filter passed a disagreeing level");
   a_force_clear: assert property (force_rst |=> !scl_oe && !sda_oe && !receive_full_flag
                                   && !transmit_empty_flag && state_reg == ST_IDLE)
      else $error("Forced reset left state behind");
   a_force_keep: assert property (force_rst && !start_det && !data_rise
                                  |=> $stable(frame_bit_counter_reg))
      else $error("Forced reset disturbed bit counter");
   a_irq_output: assert property (irq_reg && iface_irq_enable && !channel_id
                                  |=> channel0_interrupt ##0 !channel1_interrupt)
      else $error("Channel interrupt does not follow flag");
endmodule

// [istu_pkg.sv]
package istu_pkg;

   localparam int          BYTE_W     = 8;
   localparam int          ADDR_W     = 7;
   localparam int          FIFO_DEPTH = 8;
   localparam logic [2:0]  LAST_BIT   = 3'h7;
   localparam logic [2:0]  FIRST_BIT  = 3'h0;
   localparam logic [2:0]  BIT_STEP   = 3'h1;
   localparam logic [3:0]  CLR_ALL    = 4'hf;
   localparam logic [1:0]  LINES_IDLE = 2'h3;
   localparam logic [7:0]  BYTE_ZERO  = 8'h00;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_ADDR = 5'h02,
      ST_RX   = 5'h04,
      ST_TX   = 5'h08,
      ST_SKIP = 5'h10
   } istu_state_e;

endpackage

// [istu_fifo.sv]
`timescale 1ns/1ns
module istu_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(D);
   localparam int CW = $clog2(D + 1);

   logic [W-1:0]  mem_reg [D];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   wire           push = in_valid & in_ready;
   wire           pop  = out_valid & out_ready;

   assign in_ready  = (count_reg != CW'(D));
   assign out_valid = (count_reg != CW'(0));
   assign out_data  = mem_reg[rd_ptr_reg];

   // Storage needs no reset; the count alone says what is valid
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(D - 1)) ? '0 : wr_ptr_reg + AW'(1);
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(D - 1)) ? '0 : rd_ptr_reg + AW'(1);
         end
         if (push && !pop) begin
            count_reg <= count_reg + CW'(1);
         end else if (pop && !push) begin
            count_reg <= count_reg - CW'(1);
         end
      end
   end
endmodule

// [istu_bus_master.sv]
`timescale 1ns/1ns
module istu_bus_master (
   output logic      m_scl,
   output logic      m_sda,
   input  wire logic scl_line,
   input  wire logic sda_line
);
   initial begin
      m_scl = 1'b1;
      m_sda = 1'b1;
   end
   // Sample late in the high phase, since the slave answers cycles after a fall
   task automatic bit_cycle(input logic b, output logic s);
      #20 m_sda = b;
      #20 m_scl = 1'b1;
      wait (scl_line === 1'b1);
      #40 s = sda_line;
      m_scl = 1'b0;
   endtask
   task automatic start_cond();
      m_sda = 1'b0;
      #40 m_scl = 1'b0;
   endtask
   task automatic stop_cond();
      #20 m_sda = 1'b0;
      #20 m_scl = 1'b1;
      wait (scl_line === 1'b1);
      #20 m_sda = 1'b1;
      #80;
   endtask
   // MSB first, then acknowledge; a long low gap lets the slave drop its drive
   task automatic xfer(input logic [7:0] tx, input logic ack_in,
                       output logic [7:0] rx, output logic ack_out);
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(tx[i], rx[i]);
      end
      bit_cycle(ack_in, ack_out);
      #20 m_sda = 1'b1;
      #60;
   endtask
endmodule

// [iic_slave_transfer_unit_tb_top.sv]
`timescale 1ns/1ns
module iic_slave_transfer_unit_tb_top;
   import istu_pkg::*;
   logic       clk, sys_rst, m_scl, m_sda, glitch, scl_o, scl_oe, sda_o, sda_oe, ack;
   logic       interface_enable, handshake_hold_enable, ack_check_enable, end_irq_mask;
   logic       iface_irq_enable, channel_id, ack_bit_wr, ack_bit_wdata, tsel_clr;
   logic       iface_irq_clr, status_clr, clear_select_wr, data_wr, data_rd;
   logic       acknowledge_bit, transmit_select, bus_busy_flag, receive_full_flag;
   logic       transmit_empty_flag, end_flag, error_end_condition_flag;
   logic       second_address_match_flag, transfer_irq_flag, iface_irq_flag;
   logic       channel0_interrupt, channel1_interrupt;
   logic [3:0] clear_select_bits;
   logic [6:0] own_addr, second_addr;
   logic [7:0] data_wr_byte, data_rd_byte, rx;
   int         errors, tests_run;
   wire        scl_in = m_scl & ~scl_oe;
   wire        sda_in = m_sda & ~sda_oe & ~glitch;

   istu_top uut (.clk, .sys_rst, .scl_in, .sda_in, .scl_o, .scl_oe, .sda_o, .sda_oe,
      .own_addr, .second_addr, .interface_enable, .handshake_hold_enable, .ack_check_enable,
      .end_irq_mask, .iface_irq_enable, .channel_id, .ack_bit_wr, .ack_bit_wdata, .tsel_clr,
      .iface_irq_clr, .status_clr, .clear_select_wr, .clear_select_bits, .data_wr,
      .data_wr_byte, .data_rd, .data_rd_byte, .acknowledge_bit, .transmit_select,
      .bus_busy_flag, .receive_full_flag, .transmit_empty_flag, .end_flag,
      .error_end_condition_flag, .second_address_match_flag, .transfer_irq_flag,
      .iface_irq_flag, .channel0_interrupt, .channel1_interrupt);
   istu_bus_master bm (.m_scl(m_scl), .m_sda(m_sda), .scl_line(scl_in), .sda_line(sda_in));

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         errors++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk) s = 1'b1;
      @(negedge clk) s = 1'b0;
   endtask
   task automatic wr(input logic [7:0] b);
      data_wr_byte = b;
      pulse(data_wr);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic t_idle();
      chk("reset", 8'h00, {scl_oe, sda_oe, bus_busy_flag, receive_full_flag,
                           transmit_empty_flag, iface_irq_flag, end_flag, transfer_irq_flag});
      chk("pins", 8'h00, {scl_o, sda_o, error_end_condition_flag, second_address_match_flag});
      glitch = 1'b1;
      cyc(1);
      glitch = 1'b0;
      cyc(10);
      chk("glitch", 8'h00, bus_busy_flag);
   endtask
   task automatic t_rx();
      logic [7:0] d [3] = '{8'ha5, 8'h3c, 8'h81};
      bm.start_cond();
      #40 chk("busy", 8'h01, bus_busy_flag);
      bm.xfer({own_addr, 1'b0}, 1'b1, rx, ack);
      chk("addr ack", 8'h00, ack);
      for (int i = 0; i < 3; i++) begin
         if (i == 2) begin
            ack_bit_wdata = 1'b1;
            pulse(ack_bit_wr);
         end
         bm.xfer(d[i], 1'b1, rx, ack);
         chk("data ack", {7'h0, i == 2}, ack);
         chk("flags", 8'h03, {iface_irq_flag, receive_full_flag});
         chk("irq0", 8'h01, channel0_interrupt);
         pulse(iface_irq_clr);
         cyc(1);
         chk("irq0 off", 8'h00, channel0_interrupt);
      end
      chk("byte0", d[0], data_rd_byte);
      for (int i = 1; i < 4; i++) begin
         pulse(data_rd);
         cyc(2);
         chk("full", {7'h0, i < 3}, receive_full_flag);
         if (i < 3) chk("byte", d[i], data_rd_byte);
      end
      chk("reload irq", 8'h01, iface_irq_flag);
      pulse(iface_irq_clr);
      bm.stop_cond();
      chk("stop", 8'h09, {end_flag, error_end_condition_flag, bus_busy_flag, iface_irq_flag});
   endtask
   task automatic t_sec();
      pulse(iface_irq_clr);
      ack_bit_wdata = 1'b0;
      pulse(ack_bit_wr);
      channel_id = 1'b1;
      end_irq_mask = 1'b1;
      pulse(status_clr);
      bm.start_cond();
      bm.xfer({second_addr, 1'b0}, 1'b1, rx, ack);
      chk("sec ack", 8'h00, ack);
      chk("sec flags", 8'h07, {second_address_match_flag, transfer_irq_flag, iface_irq_flag});
      chk("irq1", 8'h02, {channel1_interrupt, channel0_interrupt});
      pulse(iface_irq_clr);
      bm.stop_cond();
      chk("masked stop", 8'h02, {end_flag, iface_irq_flag});
      cyc(1);
      channel_id = 1'b0;
      end_irq_mask = 1'b0;
   endtask
   task automatic t_mis();
      bm.start_cond();
      bm.xfer({7'h13, 1'b0}, 1'b1, rx, ack);
      bm.xfer(8'h55, 1'b1, rx, ack);
      chk("foreign", 8'h01, {receive_full_flag, iface_irq_flag, ack});
      bm.stop_cond();
   endtask
   task automatic t_tx();
      bm.start_cond();
      bm.xfer({own_addr, 1'b1}, 1'b1, rx, ack);
      chk("read ack", 8'h00, ack);
      chk("tx flags", 8'h07, {transmit_select, transmit_empty_flag, iface_irq_flag});
      fork
         begin
            bm.xfer(8'hff, 1'b0, rx, ack);
            chk("tx0", 8'hc3, rx);
            chk("m ack", 8'h00, acknowledge_bit);
            bm.xfer(8'hff, 1'b1, rx, ack);
            chk("tx1", 8'h5e, rx);
            chk("m nack", 8'h01, acknowledge_bit);
         end
         begin
            cyc(20);
            chk("hold", 8'h01, scl_oe);
            pulse(iface_irq_clr);
            wr(8'hc3);
            cyc(3);
            chk("reload", 8'h03, {transmit_empty_flag, iface_irq_flag});
            wr(8'h5e);
            pulse(iface_irq_clr);
         end
      join
      cyc(1);
      ack_check_enable = 1'b0;
      cyc(2);
      chk("ack clr", 8'h00, acknowledge_bit);
      chk("hold end", 8'h01, scl_oe);
      pulse(tsel_clr);
      pulse(data_rd);
      cyc(2);
      chk("sda free", 8'h00, {scl_oe, sda_oe, transmit_select});
      clear_select_bits = CLR_ALL;
      pulse(clear_select_wr);
      cyc(1);
      chk("forced", 8'h01, {scl_oe, sda_oe, transmit_empty_flag, bus_busy_flag});
      bm.stop_cond();
      cyc(1);
      interface_enable = 1'b0;
      cyc(2);
      interface_enable = 1'b1;
      ack_check_enable = 1'b1;
      cyc(6);
      chk("recover", 8'h00, {scl_oe, sda_oe, bus_busy_flag});
   endtask
   task automatic t_hold();
      handshake_hold_enable = 1'b1;
      bm.start_cond();
      bm.xfer({own_addr, 1'b0}, 1'b1, rx, ack);
      bm.xfer(8'h6b, 1'b1, rx, ack);
      cyc(2);
      chk("rx hold", 8'h03, {scl_oe, receive_full_flag});
      pulse(data_rd);
      cyc(1);
      chk("rx byte", 8'h6b, data_rd_byte);
      chk("rx release", 8'h00, {scl_oe, receive_full_flag});
      bm.stop_cond();
      handshake_hold_enable = 1'b0;
   endtask

   always #5 clk = ~clk;
   initial begin
      errors = 0;
      tests_run = 0;
      clk = 1'b0;
      sys_rst = 1'b1;
      {glitch, handshake_hold_enable, end_irq_mask, channel_id, ack_bit_wr, ack_bit_wdata,
       tsel_clr, iface_irq_clr, status_clr, clear_select_wr, data_wr, data_rd} = '0;
      {interface_enable, ack_check_enable, iface_irq_enable} = 3'h7;
      clear_select_bits = 4'h0;
      data_wr_byte = 8'h00;
      own_addr = 7'h2a;
      second_addr = 7'h51;
      repeat (20) @(negedge clk);
      sys_rst = 1'b0;
      cyc(10);
      t_idle();
      t_rx();
      t_sec();
      t_mis();
      t_tx();
      t_hold();
      print_verdict();
   end
   // Whole run is about 12 frames of roughly 1 us each
   initial begin
      #200000;
      errors++;
      print_verdict();
   end
endmodule
